// ===== include/adc_cfg_map.vh
`ifndef ADC_CFG_MAP_VH
`define ADC_CFG_MAP_VH

// Register addresses (four-bit field of the serial frame)
`define ADR_PAIR01      4'h0
`define ADR_PAIR23      4'h1
`define ADR_PAIR45      4'h2
`define ADR_PAIR67      4'h3
`define ADR_CHAN_SEL    4'h4
`define ADR_CONV_SYS    4'h5
`define ADR_IRQ_PWR     4'h6
`define ADR_EVT_FLAGS   4'h7
`define ADR_TRIG_MODE   4'h8
`define ADR_SOFT_RST    4'h9
`define ADR_SETTLE_DLY  4'ha

// Frame command codes (first two bits of a frame)
`define CMD_READ        2'h1
`define CMD_WRITE       2'h2

// Frame bit counts
`define FRAME_BITS      5'h10
`define HDR_BITS        5'h08
`define CMD_BITS        5'h02

// Channel-pair register fields
`define PAIR_GAIN_EVEN  1:0
`define PAIR_DIFF       2
`define PAIR_ODD_POL    3
`define PAIR_GAIN_ODD   5:4
`define PAIR_USED       5:0

// Converter system register fields
`define SYS_AVG         7:5
`define SYS_IRQ_EDGE    4
`define SYS_PIN_POL     3
`define SYS_PIN_BUSY    2
`define SYS_FIFO_EN     1
`define SYS_START_SRC   0

// Interrupt and power register fields
`define IRQ_PWR_DOWN    7
`define IRQ_EN          3:0

// Interrupt flag positions
`define FLG_NOT_EMPTY   3
`define FLG_FULL        2
`define FLG_SCAN        1
`define FLG_CONV        0

// Reset values
`define RST_PAIR        6'h00
`define RST_CHAN_SEL    3'h0
`define RST_CONV_SYS    8'h00
`define RST_IRQ_EN      4'h0
`define RST_TRIG_MODE   3'h2
`define RST_SETTLE_DLY  3'h0

// Soft reset key and automatic scan trigger modes
`define SOFT_RST_KEY    8'haa
`define TRIG_SCAN_ONE   3'h5
`define TRIG_SCAN_MULTI 3'h6

// Timing
`define MCLK_PERIOD_NS  8
`define IRQ_PULSE_NS    250

`endif

// ===== rtl/pin_sync2.v
`timescale 1ns/1ps

// Two-stage synchroniser for a group of independent pin levels
module pin_sync2 #(
  parameter WIDTH = 4
) (
  input  wire             i_mclk,
  input  wire             i_nrst,
  input  wire [WIDTH-1:0] i_async,
  output wire [WIDTH-1:0] o_sync
);

  reg [WIDTH-1:0] meta_ff;
  reg [WIDTH-1:0] sync_ff;

  // First stage feeds only the second stage
  always @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      meta_ff <= {WIDTH{1'b0}};
      sync_ff <= {WIDTH{1'b0}};
    end
    else
    begin
      meta_ff <= i_async;
      sync_ff <= meta_ff;
    end
  end

  assign o_sync = sync_ff;

endmodule // pin_sync2

// ===== rtl/adc_config_register_bank.v
// Overview of operation
// R1: Four-bit address picks pair registers 0-3, select 4, system 5, irq 6.
// R2: Pair register holds even gain in bits 1:0, odd gain in 5:4.
// R3: Pair bit 2 chooses two single-ended inputs or one differential input.
// R4: Pair bit 3 chooses even or odd differential polarity.
// R5: Channel select bits 2:0 name the manual channel or scan start.
// R6: System bits 7:5 choose no, fast or accurate averaging of 4/8/16.
// R7: System bit 4 makes the interrupt a level or a 250 ns pulse.
// R8: System bit 3 sets shared pin polarity, low or high active.
// R9: System bit 2 routes interrupt or busy onto the shared pin.
// R10: System bit 1 enables the result FIFO.
// R11: System bit 0 starts conversions by pin or by result read.
// R12: Interrupt register bit 7 enters power-down idle.
// R13: Interrupt register bits 6:4 always read zero.
// R14: Writes to interrupt bits 3:0 enable or disable the four interrupts.
// R15: Reads of interrupt bits 3:0 show which conditions were raised.
// R16: Scan-complete is raised only in automatic scan with auto trigger.
// R17: Every described configuration field resets to its zero code; the code resets trigger mode to 2 instead.
// R18: Host touches most registers only while the converter is idle.
// R19: Writing AAh to reset register restores defaults unless powered down.
// R20: Unused pair and select bits read zero and ignore writes.
// R21: Addresses 0Bh-0Fh are reserved: writes ignored, reads zero.
`timescale 1ns/1ps
`include "adc_cfg_map.vh"

module adc_config_register_bank (
  input  wire        i_mclk,
  input  wire        i_nrst,
  input  wire        i_sclk,
  input  wire        i_cs_n,
  input  wire        i_sdin,
  input  wire        i_convert_start_pin,
  input  wire        i_fifo_not_empty,
  input  wire        i_fifo_full,
  input  wire        i_scan_done,
  input  wire        i_conv_done,
  input  wire        i_busy,
  output wire        o_sdout,
  output wire        o_sdout_oe_n,
  output wire        o_busy_int,
  output wire [23:0] o_pair_cfg,
  output wire [2:0]  o_chan_sel,
  output wire [2:0]  o_avg_sel,
  output wire        o_fifo_en,
  output wire        o_start_src,
  output wire        o_power_down,
  output wire [2:0]  o_trig_mode,
  output wire [2:0]  o_delay_sel,
  output wire        o_conv_start,
  output wire        o_soft_rst
);

  // Interrupt pulse length, rounded down to whole clocks
  localparam integer PULSE_RAW = `IRQ_PULSE_NS / `MCLK_PERIOD_NS;
  localparam [5:0]   PULSE_CYC = (PULSE_RAW < 1) ? 6'h01
                                                 : PULSE_RAW[5:0];

  wire [3:0]  pins_s;
  wire        sclk_s;
  wire        cs_n_s;
  wire        sdin_s;
  wire        start_s;

  reg         sclk_d_ff;
  reg         start_d_ff;
  reg  [4:0]  cnt_ff;
  reg  [15:0] shin_ff;
  reg  [7:0]  tx_ff;
  reg         sdout_ff;
  reg         bit_done_ff;

  reg  [23:0] pair_ff;
  reg  [2:0]  chan_ff;
  reg  [7:0]  sys_ff;
  reg         pd_ff;
  reg  [3:0]  irq_en_ff;
  reg  [2:0]  trig_ff;
  reg  [2:0]  dly_ff;
  reg  [3:0]  flags_ff;
  reg         srst_ff;
  reg         conv_start_ff;
  reg         irq_any_d_ff;
  reg  [5:0]  pulse_cnt_ff;
  reg         pin_ff;

  reg  [7:0]  rd_data;
  reg  [3:0]  nxt_flags;

  wire        sclk_rise;
  wire        sclk_fall;
  wire [1:0]  fr_cmd;
  wire [3:0]  fr_addr;
  wire [7:0]  fr_data;
  wire        hdr_done;
  wire        frm_done;
  wire        wr_stb;
  wire        rd_irq_end;
  wire        soft_rst;
  wire        res_read;
  wire        scan_mode;
  wire [3:0]  set_flags;
  wire        irq_any;
  wire        int_active;
  wire        pin_active;

  // Pins from the host and the start pin cross into i_mclk here
  pin_sync2 #(
    .WIDTH (4)
  ) u_sync (
    .i_mclk  (i_mclk),
    .i_nrst  (i_nrst),
    .i_async ({i_convert_start_pin, i_sdin, i_cs_n, i_sclk}),
    .o_sync  (pins_s)
  );

  assign sclk_s  = pins_s[0];
  assign cs_n_s  = pins_s[1];
  assign sdin_s  = pins_s[2];
  assign start_s = pins_s[3];

  // Edges of the sampled link clock
  assign sclk_rise = sclk_s & ~sclk_d_ff;
  assign sclk_fall = ~sclk_s & sclk_d_ff;

  // Frame fields, valid once the whole header or frame is in
  assign fr_cmd  = (cnt_ff == `FRAME_BITS) ? shin_ff[15:14] : shin_ff[7:6];
  assign fr_addr = (cnt_ff == `FRAME_BITS) ? shin_ff[13:10] : shin_ff[5:2];
  assign fr_data = shin_ff[7:0];

  assign hdr_done   = bit_done_ff && (cnt_ff == `HDR_BITS);
  assign frm_done   = bit_done_ff && (cnt_ff == `FRAME_BITS);
  assign wr_stb     = frm_done && (fr_cmd == `CMD_WRITE);
  assign rd_irq_end = frm_done && (fr_cmd == `CMD_READ) &&
                      (fr_addr == `ADR_IRQ_PWR);

  // Result read: a frame whose command is neither read nor write
  assign res_read = bit_done_ff && (cnt_ff == `CMD_BITS) &&
                    (shin_ff[1:0] != `CMD_READ) &&
                    (shin_ff[1:0] != `CMD_WRITE);

  // R19: key write
  assign soft_rst = wr_stb && (fr_addr == `ADR_SOFT_RST) &&
                    (fr_data == `SOFT_RST_KEY) && !pd_ff;

  // Serial shift engine; bits are taken on sampled rising edges
  always @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      sclk_d_ff   <= 1'b0;
      cnt_ff      <= 5'h00;
      shin_ff     <= 16'h0000;
      bit_done_ff <= 1'b0;
    end
    else
    begin
      sclk_d_ff   <= sclk_s;
      bit_done_ff <= 1'b0;
      if (cs_n_s)
        cnt_ff <= 5'h00;
      else if (sclk_rise && (cnt_ff != `FRAME_BITS))
      begin
        shin_ff     <= {shin_ff[14:0], sdin_s};
        cnt_ff      <= cnt_ff + 5'h01;
        bit_done_ff <= 1'b1;
      end
    end
  end

  // R1: address decode
  // R13: fixed zeros
  // R20: unused bits read zero
  always @*
  begin
    rd_data = 8'h00;
    case (fr_addr)
      `ADR_PAIR01:     rd_data = {2'h0, pair_ff[5:0]};
      `ADR_PAIR23:     rd_data = {2'h0, pair_ff[11:6]};
      `ADR_PAIR45:     rd_data = {2'h0, pair_ff[17:12]};
      `ADR_PAIR67:     rd_data = {2'h0, pair_ff[23:18]};
      `ADR_CHAN_SEL:   rd_data = {5'h00, chan_ff};
      `ADR_CONV_SYS:   rd_data = sys_ff;
      // R15: raised conditions
      `ADR_IRQ_PWR:    rd_data = {pd_ff, 3'h0, flags_ff};
      `ADR_EVT_FLAGS:  rd_data = {4'h0, i_fifo_not_empty, i_fifo_full,
                                  i_scan_done, i_conv_done};
      `ADR_TRIG_MODE:  rd_data = {5'h00, trig_ff};
      `ADR_SETTLE_DLY: rd_data = {5'h00, dly_ff};
      // R21: reserved reads zero
      default:         rd_data = 8'h00;
    endcase
  end

  // Read data leaves on falling edges, after the eight header bits
  always @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      tx_ff    <= 8'h00;
      sdout_ff <= 1'b0;
    end
    else if (cs_n_s)
    begin
      tx_ff    <= 8'h00;
      sdout_ff <= 1'b0;
    end
    else if (hdr_done && (fr_cmd == `CMD_READ))
      tx_ff <= rd_data;
    else if (sclk_fall && (cnt_ff >= `HDR_BITS))
    begin
      sdout_ff <= tx_ff[7];
      tx_ff    <= {tx_ff[6:0], 1'b0};
    end
  end

  // Pad is driven only while the host selects the device
  assign o_sdout      = sdout_ff;
  assign o_sdout_oe_n = cs_n_s;

  // Register writes; the soft reset restores defaults two clocks after the key
  always @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      // R17: zero defaults, except trigger mode 2
      pair_ff   <= {4{`RST_PAIR}};
      chan_ff   <= `RST_CHAN_SEL;
      sys_ff    <= `RST_CONV_SYS;
      pd_ff     <= 1'b0;
      irq_en_ff <= `RST_IRQ_EN;
      trig_ff   <= `RST_TRIG_MODE;
      dly_ff    <= `RST_SETTLE_DLY;
      srst_ff   <= 1'b0;
    end
    else if (srst_ff)
    begin
      // R19: restore defaults
      pair_ff   <= {4{`RST_PAIR}};
      chan_ff   <= `RST_CHAN_SEL;
      sys_ff    <= `RST_CONV_SYS;
      pd_ff     <= 1'b0;
      irq_en_ff <= `RST_IRQ_EN;
      trig_ff   <= `RST_TRIG_MODE;
      dly_ff    <= `RST_SETTLE_DLY;
      srst_ff   <= 1'b0;
    end
    else
    begin
      srst_ff <= soft_rst;
      if (wr_stb)
      begin
        case (fr_addr)
          // R2: gain fields
          // R3: pairing bit
          // R4: polarity bit
          `ADR_PAIR01: pair_ff[5:0]   <= fr_data[`PAIR_USED];
          `ADR_PAIR23: pair_ff[11:6]  <= fr_data[`PAIR_USED];
          `ADR_PAIR45: pair_ff[17:12] <= fr_data[`PAIR_USED];
          `ADR_PAIR67: pair_ff[23:18] <= fr_data[`PAIR_USED];
          // R5: channel number
          `ADR_CHAN_SEL: chan_ff <= fr_data[2:0];
          `ADR_CONV_SYS: sys_ff <= fr_data;
          `ADR_IRQ_PWR:
          begin
            // R12: power-down bit
            pd_ff     <= fr_data[`IRQ_PWR_DOWN];
            // R14: interrupt enables
            irq_en_ff <= fr_data[`IRQ_EN];
          end
          `ADR_TRIG_MODE:  trig_ff <= fr_data[2:0];
          `ADR_SETTLE_DLY: dly_ff  <= fr_data[2:0];
          // R21: reserved writes ignored
          default: pd_ff <= pd_ff;
        endcase
      end
    end
  end

  // R16: scan gating
  assign scan_mode = (trig_ff == `TRIG_SCAN_ONE) ||
                     (trig_ff == `TRIG_SCAN_MULTI);

  assign set_flags = {i_fifo_not_empty, i_fifo_full,
                      i_scan_done & scan_mode, i_conv_done};

  // R15: sticky flags
  // Cleared by reading the interrupt register; a new event wins
  always @*
  begin
    nxt_flags = flags_ff;
    if (rd_irq_end)
      nxt_flags = 4'h0;
    nxt_flags = nxt_flags | set_flags;
  end

  always @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
      flags_ff <= 4'h0;
    else if (srst_ff)
      flags_ff <= 4'h0;
    else
      flags_ff <= nxt_flags;
  end

  // Only enabled flags reach the interrupt output
  assign irq_any = |(flags_ff & irq_en_ff);

  // R7: pulse timer
  // Only a rise of irq_any starts the pulse; pending flags do not repeat it
  always @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      irq_any_d_ff <= 1'b0;
      pulse_cnt_ff <= 6'h00;
    end
    else
    begin
      irq_any_d_ff <= irq_any;
      if (irq_any && !irq_any_d_ff)
        pulse_cnt_ff <= PULSE_CYC;
      else if (pulse_cnt_ff != 6'h00)
        pulse_cnt_ff <= pulse_cnt_ff - 6'h01;
    end
  end

  // R7: level or pulse
  assign int_active = sys_ff[`SYS_IRQ_EDGE] ? (pulse_cnt_ff != 6'h00)
                                            : irq_any;
  // R9: pin function
  assign pin_active = sys_ff[`SYS_PIN_BUSY] ? i_busy : int_active;

  // Shared pin is registered so polarity changes never glitch it
  always @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
      pin_ff <= 1'b1;
    else
      // R8: pin polarity
      pin_ff <= sys_ff[`SYS_PIN_POL] ? pin_active : ~pin_active;
  end

  // R11: start source
  // Power-down holds off every start request
  always @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      start_d_ff    <= 1'b0;
      conv_start_ff <= 1'b0;
    end
    else
    begin
      start_d_ff <= start_s;
      if (pd_ff || srst_ff)
        conv_start_ff <= 1'b0;
      else if (sys_ff[`SYS_START_SRC])
        conv_start_ff <= res_read;
      else
        conv_start_ff <= start_s & ~start_d_ff;
    end
  end

  assign o_busy_int   = pin_ff;
  assign o_pair_cfg   = pair_ff;
  assign o_chan_sel   = chan_ff;
  // R6: averaging code
  assign o_avg_sel    = sys_ff[`SYS_AVG];
  // R10: FIFO enable
  assign o_fifo_en    = sys_ff[`SYS_FIFO_EN];
  assign o_start_src  = sys_ff[`SYS_START_SRC];
  assign o_power_down = pd_ff;
  assign o_trig_mode  = trig_ff;
  assign o_delay_sel  = dly_ff;
  assign o_conv_start = conv_start_ff;
  assign o_soft_rst   = srst_ff;

endmodule // adc_config_register_bank

// ===== sim/adc_bank_monitor.sv
`timescale 1ns/1ps

// Ties config and pulse outputs to their causes at the pins
module adc_bank_monitor (
  input wire        i_mclk,
  input wire        i_nrst,
  input wire        i_cs_n,
  input wire        i_convert_start_pin,
  input wire [23:0] o_pair_cfg,
  input wire [2:0]  o_chan_sel,
  input wire [2:0]  o_avg_sel,
  input wire        o_start_src,
  input wire        o_power_down,
  input wire [2:0]  o_trig_mode,
  input wire        o_conv_start,
  input wire        o_soft_rst
);
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_nrst);

  reset_vals_a: assert property (!$past(i_nrst) |->
    o_trig_mode == 3'h2 && o_pair_cfg == 24'h0 && !o_power_down)
    else $error("config not at defaults after reset");
  soft_clear_a: assert property (o_soft_rst |-> ##[1:2]
    (o_chan_sel == 3'h0 && o_trig_mode == 3'h2 && o_avg_sel == 3'h0))
    else $error("soft reset left config set");
  pd_no_rst_a: assert property (o_soft_rst |-> !o_power_down)
    else $error("soft reset while powered down");
  start_one_a: assert property (o_conv_start |=> !o_conv_start)
    else $error("start pulse longer than one cycle");
  pin_start_a: assert property ($rose(i_convert_start_pin) &&
    !o_start_src && !o_power_down |-> ##[1:4] o_conv_start)
    else $error("pin edge gave no start");
  src_pin_only_a: assert property (i_cs_n [*6] ##0 o_start_src
    |-> !o_conv_start)
    else $error("start without a frame in serial mode");
  pd_no_start_a: assert property (o_power_down |-> !o_conv_start)
    else $error("start while powered down");
  // writes only by frames; long idle means no late commit
  cfg_quiet_a: assert property (i_cs_n [*8] |=> $stable(o_pair_cfg) &&
    $stable(o_avg_sel) && $stable(o_chan_sel))
    else $error("config changed with link idle");

  // Main scenarios reached
  cover property (o_soft_rst);
  cover property (o_conv_start && o_start_src);
  cover property ($rose(o_power_down));
endmodule // adc_bank_monitor

bind adc_config_register_bank adc_bank_monitor u_mon (
  .i_mclk(i_mclk), .i_nrst(i_nrst), .i_cs_n(i_cs_n),
  .i_convert_start_pin(i_convert_start_pin), .o_pair_cfg(o_pair_cfg),
  .o_chan_sel(o_chan_sel), .o_avg_sel(o_avg_sel),
  .o_start_src(o_start_src), .o_power_down(o_power_down),
  .o_trig_mode(o_trig_mode), .o_conv_start(o_conv_start),
  .o_soft_rst(o_soft_rst)
);

// ===== sim/spi_host_model.sv
`timescale 1ns/1ps

// Host end of the serial link; clock stands low between frames
module spi_host_model (
  input  wire i_mclk,
  input  wire i_sdout,
  input  wire i_sdout_oe_n,
  output reg  o_sclk,
  output reg  o_cs_n,
  output reg  o_sdin
);
  // 40 ns phases give the 80 ns link period
  localparam int HALF = 5;

  // Idle levels at time zero
  initial
  begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_sdin = 1'b0;
  end

  // idle-only access is the caller's duty
  task automatic xfer(input logic [15:0] tx, output logic [7:0] rx);
    int i;
    rx = 8'h00;
    @(posedge i_mclk);
    o_cs_n <= 1'b0;
    for (i = 15; i >= 0; i--)
    begin
      o_sdin <= tx[i];
      repeat (HALF) @(posedge i_mclk);
      o_sclk <= 1'b1;
      // Undriven line gives junk, not a stale level
      if (i < 8)
        rx = {rx[6:0], i_sdout_oe_n ? ~rx[0] : i_sdout};
      repeat (HALF) @(posedge i_mclk);
      o_sclk <= 1'b0;
    end
    o_cs_n <= 1'b1;
    o_sdin <= ~o_sdin;
    // Gap lets the sync chain see the deselect
    repeat (8) @(posedge i_mclk);
  endtask
endmodule // spi_host_model

// ===== sim/tb.sv
`timescale 1ns/1ps
`include "adc_cfg_map.vh"

module tb;
  localparam int LIMIT = 40000;
  logic        clk = 1'b0, nrst = 1'b0, pin = 1'b0, busy = 1'b0;
  logic        ne = 1'b0, full = 1'b0, scan = 1'b0, conv = 1'b0;
  wire         sclk, cs_n, sdin, sdo, sdo_oe_n, bi, fifo, src, pd;
  wire         cst, srst;
  wire  [23:0] pair;
  wire  [2:0]  chan, avg, trig, dly;
  logic [7:0]  rx, d;
  int          errors = 0, checks = 0, cyc = 0, starts = 0, k, n, hi = 0;

  adc_config_register_bank u_dut (
    .i_mclk(clk), .i_nrst(nrst), .i_sclk(sclk), .i_cs_n(cs_n),
    .i_sdin(sdin), .i_convert_start_pin(pin), .i_fifo_not_empty(ne),
    .i_fifo_full(full), .i_scan_done(scan), .i_conv_done(conv),
    .i_busy(busy), .o_sdout(sdo), .o_sdout_oe_n(sdo_oe_n),
    .o_busy_int(bi), .o_pair_cfg(pair), .o_chan_sel(chan),
    .o_avg_sel(avg), .o_fifo_en(fifo), .o_start_src(src),
    .o_power_down(pd), .o_trig_mode(trig), .o_delay_sel(dly),
    .o_conv_start(cst), .o_soft_rst(srst)
  );
  spi_host_model u_host (
    .i_mclk(clk), .i_sdout(sdo), .i_sdout_oe_n(sdo_oe_n),
    .o_sclk(sclk), .o_cs_n(cs_n), .o_sdin(sdin)
  );

  // 125 MHz clock
  always #4 clk = ~clk;

  // Start pulses and hang guard
  always @(posedge clk)
  begin
    cyc++;
    if (cst === 1'b1)
      starts++;
    // High cycles of the shared pin, for pulse length checks
    if (bi === 1'b1)
      hi++;
    if (cyc == LIMIT)
    begin
      errors++;
      end_sim;
    end
  end

  task automatic tick(input int c);
    repeat (c) @(posedge clk);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    u_host.xfer({`CMD_WRITE, a, 2'b00, v}, rx);
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    u_host.xfer({`CMD_READ, a, 10'h000}, rx);
    chk(rx, e);
  endtask
  task automatic kick;
    pin <= 1'b1;
    tick(8);
    pin <= 1'b0;
    tick(8);
  endtask
  // Event inputs are one-cycle pulses from the core
  task automatic hit(input int w);
    if (w == 0)
      conv <= 1'b1;
    else
      scan <= 1'b1;
    tick(1);
    conv <= 1'b0;
    scan <= 1'b0;
    tick(4);
  endtask
  task automatic end_sim;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Register sequence
  initial
  begin
    tick(10);
    nrst <= 1'b1;
    tick(4);
    for (k = 0; k < 7; k++)
      rd(k[3:0], 8'h00);
    chk({pair, trig, dly, bi}, {24'h0, 3'h2, 3'h0, 1'b1});
    for (k = 0; k < 4; k++)
    begin
      d = 8'hff ^ (8'h15 * k[7:0]);
      wr(k[3:0], d);
      rd(k[3:0], d & 8'h3f);
      chk(pair[6*k +: 6], d[5:0]);
    end
    wr(4'h4, 8'hfd);
    rd(4'h4, 8'h05);
    chk(chan, 3'h5);
    wr(4'ha, 8'hfb);
    rd(4'ha, 8'h03);
    chk(dly, 3'h3);
    for (k = 0; k < 8; k++)
    begin
      wr(4'h5, {k[2:0], 5'h00});
      chk(avg, k[2:0]);
    end
    wr(4'h5, 8'h02);
    chk({fifo, src}, 2'b10);
    kick;
    chk(starts, 1);
    wr(4'h5, 8'h01);
    kick;
    // Result-read frame: this first read is thrown away
    u_host.xfer(16'h0000, rx);
    chk(starts, 2);
    wr(4'h6, 8'h01);
    hit(0);
    chk(bi, 1'b0);
    rd(4'h6, 8'h01);
    tick(3);
    chk(bi, 1'b1);
    wr(4'h5, 8'h08);
    chk(bi, 1'b0);
    wr(4'h5, 8'h18);
    // Count from before the event so the first pulse cycle is not missed
    n = hi;
    hit(0);
    tick(55);
    chk(hi - n, 31);
    rd(4'h6, 8'h01);
    wr(4'h5, 8'h0c);
    busy <= 1'b1;
    tick(4);
    chk(bi, 1'b1);
    busy <= 1'b0;
    tick(4);
    chk(bi, 1'b0);
    wr(4'h5, 8'h08);
    wr(4'h6, 8'h00);
    hit(0);
    chk(bi, 1'b0);
    rd(4'h6, 8'h01);
    wr(4'h6, 8'h7f);
    hit(1);
    rd(4'h6, 8'h00);
    wr(4'h8, 8'h05);
    hit(1);
    rd(4'h6, 8'h02);
    ne <= 1'b1;
    full <= 1'b1;
    rd(4'h7, 8'h0c);
    ne <= 1'b0;
    full <= 1'b0;
    rd(4'h6, 8'h0c);
    wr(4'h6, 8'h80);
    rd(4'h6, 8'h80);
    wr(4'h9, 8'haa);
    kick;
    chk({pd, trig, starts[3:0]}, {1'b1, 3'h5, 4'h2});
    wr(4'h6, 8'h00);
    wr(4'h9, 8'h55);
    chk(trig, 3'h5);
    wr(4'h9, 8'haa);
    chk({pair, trig, chan}, {24'h0, 3'h2, 3'h0});
    chk({avg, dly}, 6'h00);
    rd(4'h5, 8'h00);
    for (k = 11; k < 16; k++)
    begin
      wr(k[3:0], 8'hff);
      rd(k[3:0], 8'h00);
    end
    chk({pair, chan}, 27'h0);
    end_sim;
  end
endmodule // tb
